// ---- verilog/radio_config_register_map.sv ----
/*
  Configuration and status register map of a sub-GHz packet radio, reached
  by the host over a four-wire serial peripheral link (mode 0, MSB first).
  Assumes the link pins are already synchronous to clk and that the serial
  clock runs at most clk/4, so every link edge spans two or more clk cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module radio_config_register_map
   import radio_config_pkg::*;
#(
   parameter int SEQ_CYCLES = SEQ_STEP_CYCLES  // Settling time per sequencer step
) (
   input  wire logic           clk,
   input  wire logic           reset,
   input  wire logic           spiSck,             // Serial clock, idles low
   input  wire logic           spiMosi,            // Host to device data
   input  wire logic           spiSelectN,         // Frame select, low active
   output logic                spiMisoOut,         // Device to host data
   output logic                spiMisoOe,          // High while driving spiMisoOut
   input  wire logic           afcRunning,         // Frequency correction in progress
   input  wire radio_status_t  statusIn,           // Event flags from the radio core
   input  wire radio_measure_t measureIn,          // Measured values from the core
   input  wire logic [7:0]     fifoReadData,       // Byte at the head of the FIFO
   output logic                fifoReadStrobe,     // Pops one FIFO byte
   output logic                fifoWriteStrobe,    // Pushes fifoWriteData
   output logic [7:0]          fifoWriteData,      // Byte written by the host
   output radio_ctrl_t         ctrl                // Settings for the radio core
);

   // Counter too small for one cycle is useless
   initial begin
      if (SEQ_CYCLES < 1 || SEQ_CYCLES > 65535) begin
         $error("SEQ_CYCLES out of range");
      end
   end

   // Sequencer states
   typedef enum logic [1:0] {
      SEQ_IDLE   = 2'b01,
      SEQ_SETTLE = 2'b10
   } seq_state_t;

   // All state of the block
   typedef struct packed {
      logic [127:0][7:0] regs;        // Byte storage, one per address
      logic [2:0]        actualMode;  // Mode the chip is in now
      seq_state_t        seqState;    // Sequencer progress
      logic [15:0]       settleCnt;   // Cycles left in a sequencer step
      logic              listen_abort_strobe; // One-cycle abort pulse
      logic              sckPrev;     // Serial clock of last cycle
      logic [2:0]        bitCnt;      // Bits taken in the current byte
      logic [7:0]        inShift;     // Incoming byte
      logic [7:0]        outShift;    // Outgoing byte, MSB on the line
      logic              addrPhase;   // First byte of the frame pending
      logic              isWrite;     // Frame direction
      logic [6:0]        addr;        // Current access address
      logic              fifoRd;      // FIFO pop pulse
      logic              fifoWr;      // FIFO push pulse
      logic [7:0]        fifoWrData;  // Byte for the FIFO
   } state_t;

   state_t state;       // Registered state
   state_t next_state;  // Value for the next edge

   // Mode field as the host last wrote it
   logic [2:0] requestedMode;
   assign requestedMode = state.regs[ADDR_OP_MODE][OPM_MODE_HI:OPM_MODE_LO];

   // Sequencer is active when its disable bit is clear
   logic seqEnabled;
   assign seqEnabled = !state.regs[ADDR_OP_MODE][OPM_SEQ_OFF_BIT];

   // Only the five defined codes are ever entered
   function automatic logic modeLegal(input logic [2:0] m);
      modeLegal = (m <= MODE_RX);
   endfunction

   // One step toward the target: up through standby and synthesizer
   function automatic logic [2:0] stepToward(input logic [2:0] cur,
                                             input logic [2:0] tgt);
      if (tgt < cur || tgt == MODE_SLEEP) begin
         stepToward = tgt;
      end else if (cur == MODE_SLEEP) begin
         stepToward = MODE_STANDBY;
      end else if (cur == MODE_STANDBY && tgt != MODE_STANDBY) begin
         stepToward = MODE_SYNTH;
      end else begin
         stepToward = tgt;
      end
   endfunction

   // Byte seen by a host read at a given address
   function automatic logic [7:0] readValue(input state_t s, input logic [6:0] a);
      unique case (a)
         ADDR_FIFO:    readValue = fifoReadData;
         // Abort always reads zero and unused low bits read zero
         ADDR_OP_MODE: readValue = {s.regs[ADDR_OP_MODE][7:6], 1'b0,
                                    s.actualMode, 2'b00};
         ADDR_AFC_HI:  readValue = measureIn.afcHigh;
         ADDR_AFC_LO:  readValue = measureIn.afcLow;
         ADDR_FEI_HI:  readValue = measureIn.feiHigh;
         ADDR_FEI_LO:  readValue = measureIn.feiLow;
         ADDR_RSSI_VAL: readValue = measureIn.rssi;
         // Top bit tells the requested mode has been reached
         ADDR_FLAGS_1: readValue = {s.actualMode == requestedMode,
                                    statusIn.flagsFirst};
         ADDR_FLAGS_2: readValue = {statusIn.flagsSecond, 1'b0};
         ADDR_TEMP_VAL: readValue = measureIn.temp;
         default:      readValue = isStored(a) ? s.regs[a] : 8'h00;
      endcase
   endfunction

   // Next state: serial link, register writes, mode sequencer
   always_comb begin
      logic       sckRise;
      logic       sckFall;
      logic [7:0] byteIn;
      logic [6:0] a;
      sckRise = 1'b0;
      sckFall = 1'b0;
      byteIn  = 8'h00;
      a       = 7'h00;
      next_state             = state;
      next_state.sckPrev     = spiSck;
      next_state.listen_abort_strobe = 1'b0;
      next_state.fifoRd      = 1'b0;
      next_state.fifoWr      = 1'b0;

      if (reset) begin
         // Every location reloads its built-in value
         for (int i = 0; i < 128; i++) begin
            next_state.regs[i] = resetValue(7'(i));
         end
         next_state.actualMode = MODE_STANDBY;
         next_state.seqState   = SEQ_IDLE;
         next_state.settleCnt  = 16'h0000;
         next_state.sckPrev    = 1'b0;
         next_state.bitCnt     = 3'h0;
         next_state.inShift    = 8'h00;
         next_state.outShift   = 8'h00;
         next_state.addrPhase  = 1'b1;
         next_state.isWrite    = 1'b0;
         next_state.addr       = 7'h00;
         next_state.fifoWrData = 8'h00;
      end else begin
         sckRise = spiSck && !state.sckPrev;
         sckFall = !spiSck && state.sckPrev;

         if (spiSelectN) begin
            // No frame: rearm for the next address byte
            next_state.bitCnt    = 3'h0;
            next_state.addrPhase = 1'b1;
            next_state.outShift  = 8'h00;
         end else if (sckRise) begin
            byteIn = {state.inShift[6:0], spiMosi};
            next_state.inShift = byteIn;
            next_state.bitCnt  = state.bitCnt + 3'h1;
            if (state.bitCnt == 3'h7) begin
               if (state.addrPhase) begin
                  // First byte: direction bit then address
                  a = byteIn[6:0];
                  next_state.addrPhase = 1'b0;
                  next_state.isWrite   = byteIn[7];
                  next_state.addr      = a;
               end else begin
                  // Data byte done; burst moves to the next address
                  a = state.addr;
                  if (state.isWrite) begin
                     if (a == ADDR_FIFO) begin
                        next_state.fifoWr     = 1'b1;
                        next_state.fifoWrData = byteIn;
                     end else if (a == ADDR_OP_MODE) begin
                        // Abort bit is a strobe and is never stored
                        next_state.regs[a] = {byteIn[7:6], 1'b0,
                                              byteIn[4:2], 2'b00};
                        if (byteIn[OPM_ABORT_BIT] && !byteIn[OPM_LISTEN_BIT]) begin
                           next_state.listen_abort_strobe = 1'b1;
                        end
                     end else if (a == ADDR_DATA_MOD) begin
                        next_state.regs[a] = byteIn & DM_WRITE_MASK;
                     end else if (isStored(a)) begin
                        next_state.regs[a] = byteIn;
                     end
                  end
                  a = state.addr + 7'h1;
                  next_state.addr = a;
               end
               // Load the byte the host will clock out next
               if (!state.addrPhase || !byteIn[7]) begin
                  next_state.outShift = readValue(state, a);
                  next_state.fifoRd   = (a == ADDR_FIFO)
                                        && !(state.addrPhase ? byteIn[7] : state.isWrite);
               end
            end
         end else if (sckFall && state.bitCnt != 3'h0) begin
            // Shift on falling edges, but not right after a fresh load
            next_state.outShift = {state.outShift[6:0], 1'b0};
         end

         // Mode sequencer
         unique case (state.seqState)
            SEQ_IDLE: begin
               if (modeLegal(requestedMode) && state.actualMode != requestedMode) begin
                  if (seqEnabled) begin
                     next_state.seqState  = SEQ_SETTLE;
                     next_state.settleCnt = 16'(SEQ_CYCLES - 1);
                  end else begin
                     // Forced: the mode is applied as written
                     next_state.actualMode = requestedMode;
                  end
               end
            end
            SEQ_SETTLE: begin
               if (!seqEnabled) begin
                  // Host took over mid-step; back to idle, which applies its mode next cycle
                  next_state.seqState = SEQ_IDLE;
               end else if (state.settleCnt == 16'h0000) begin
                  next_state.seqState = SEQ_IDLE;
                  // A reserved request leaves the mode where it is
                  if (modeLegal(requestedMode)) begin
                     next_state.actualMode = stepToward(state.actualMode,
                                                        requestedMode);
                  end
               end else begin
                  next_state.settleCnt = state.settleCnt - 16'h0001;
               end
            end
            default: begin
               next_state.seqState = SEQ_IDLE;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clk) begin
      state <= next_state;
   end

   // Serial output: driven only inside a frame
   assign spiMisoOut = state.outShift[7];
   assign spiMisoOe  = !spiSelectN;

   // FIFO strobes
   assign fifoReadStrobe  = state.fifoRd;
   assign fifoWriteStrobe = state.fifoWr;
   assign fifoWriteData   = state.fifoWrData;

   // Shaping depends on modulation; reserved combinations say so
   shaping_t shapeSel;
   always_comb begin
      logic [1:0] code;
      code = state.regs[ADDR_DATA_MOD][DM_SHAPE_HI:DM_SHAPE_LO];
      if (state.regs[ADDR_DATA_MOD][DM_MOD_HI:DM_MOD_LO] == MOD_FSK) begin
         unique case (code)
            2'h0:    shapeSel = SHAPE_NONE;
            2'h1:    shapeSel = SHAPE_BT_10;
            2'h2:    shapeSel = SHAPE_BT_05;
            default: shapeSel = SHAPE_BT_03;
         endcase
      end else if (state.regs[ADDR_DATA_MOD][DM_MOD_HI:DM_MOD_LO] == MOD_OOK) begin
         unique case (code)
            2'h0:    shapeSel = SHAPE_NONE;
            2'h1:    shapeSel = SHAPE_CUT_1;
            2'h2:    shapeSel = SHAPE_CUT_2;
            default: shapeSel = SHAPE_RSVD;
         endcase
      end else begin
         shapeSel = SHAPE_RSVD;
      end
   end

   // Control outputs: stored bytes, plus mode state, abort strobe, decoded shaping and selected bandwidth
   always_comb begin
      ctrl                      = '0;
      ctrl.actualMode           = state.actualMode;
      ctrl.modeReady            = state.actualMode == requestedMode;
      ctrl.listenEnable         = state.regs[ADDR_OP_MODE][OPM_LISTEN_BIT];
      ctrl.listenAbortPulse     = state.listen_abort_strobe;
      // Code 01 is reserved and passed on without meaning
      ctrl.dataProcessing       = state.regs[ADDR_DATA_MOD][DM_PROC_HI:DM_PROC_LO];
      ctrl.modulationType       = state.regs[ADDR_DATA_MOD][DM_MOD_HI:DM_MOD_LO];
      ctrl.shaping              = shapeSel;
      ctrl.bitRateDivisorHigh   = state.regs[ADDR_BIT_RATE_DIVISOR_HI];
      // Correction bandwidth replaces the normal one only while correcting
      ctrl.channelBandwidth     = afcRunning ? state.regs[ADDR_AFC_BW]
                                             : state.regs[ADDR_RX_BW];
      for (int p = 0; p < 4; p++) begin
         ctrl.digitalPinSelectLow[p] = state.regs[ADDR_PIN_MAP_LO][7 - 2 * p -: 2];
      end
      ctrl.digitalPinFourSelect = state.regs[ADDR_PIN_MAP_HI][7:6];
      ctrl.digitalPinFiveSelect = state.regs[ADDR_PIN_MAP_HI][5:4];
      ctrl.clockOutputDivide    = state.regs[ADDR_PIN_MAP_HI][2:0];
      ctrl.rxDetectTimeout      = state.regs[ADDR_RX_TMO_1];
      ctrl.rxPayloadTimeout     = state.regs[ADDR_RX_TMO_2];
      for (int b = 0; b < 8; b++) begin
         ctrl.syncWord[7 - b] = state.regs[ADDR_SYNC_FIRST + 7'(b)];
      end
      ctrl.fifoThreshold        = state.regs[ADDR_FIFO_THR];
      for (int k = 0; k < 16; k++) begin
         ctrl.cipherKey[15 - k] = state.regs[ADDR_KEY_FIRST + 7'(k)];
      end
   end

endmodule // radio_config_register_map

`default_nettype wire

// ---- pkg/radio_config_pkg.sv ----
/*
  Package for the radio configuration register map: register addresses,
  reset values, mode and field encodings, sequencer timing, carrier structs.
  Assumes one 250 MHz core clock and byte-wide registers on a 7-bit address.
*/
package radio_config_pkg;

   // Address map
   localparam logic [6:0] ADDR_FIFO        = 7'h00;
   localparam logic [6:0] ADDR_OP_MODE     = 7'h01;
   localparam logic [6:0] ADDR_DATA_MOD    = 7'h02;
   localparam logic [6:0] ADDR_BIT_RATE_DIVISOR_HI  = 7'h03;
   localparam logic [6:0] ADDR_RX_BW       = 7'h19;
   localparam logic [6:0] ADDR_AFC_BW      = 7'h1a;
   localparam logic [6:0] ADDR_OOK_PEAK    = 7'h1b;
   localparam logic [6:0] ADDR_OOK_AVG     = 7'h1c;
   localparam logic [6:0] ADDR_OOK_FIX     = 7'h1d;
   localparam logic [6:0] ADDR_AFC_CTRL    = 7'h1e;
   localparam logic [6:0] ADDR_AFC_HI      = 7'h1f;
   localparam logic [6:0] ADDR_AFC_LO      = 7'h20;
   localparam logic [6:0] ADDR_FEI_HI      = 7'h21;
   localparam logic [6:0] ADDR_FEI_LO      = 7'h22;
   localparam logic [6:0] ADDR_RSSI_CFG    = 7'h23;
   localparam logic [6:0] ADDR_RSSI_VAL    = 7'h24;
   localparam logic [6:0] ADDR_PIN_MAP_LO  = 7'h25;
   localparam logic [6:0] ADDR_PIN_MAP_HI  = 7'h26;
   localparam logic [6:0] ADDR_FLAGS_1     = 7'h27;
   localparam logic [6:0] ADDR_FLAGS_2     = 7'h28;
   localparam logic [6:0] ADDR_RSSI_THR    = 7'h29;
   localparam logic [6:0] ADDR_RX_TMO_1    = 7'h2a;
   localparam logic [6:0] ADDR_RX_TMO_2    = 7'h2b;
   localparam logic [6:0] ADDR_PREAMB_LO   = 7'h2d;
   localparam logic [6:0] ADDR_SYNC_CFG    = 7'h2e;
   localparam logic [6:0] ADDR_SYNC_FIRST  = 7'h2f;
   localparam logic [6:0] ADDR_SYNC_LAST   = 7'h36;
   localparam logic [6:0] ADDR_PKT_CFG_1   = 7'h37;
   localparam logic [6:0] ADDR_PAYLOAD_LEN = 7'h38;
   localparam logic [6:0] ADDR_AUTO_MODES  = 7'h3b;
   localparam logic [6:0] ADDR_FIFO_THR    = 7'h3c;
   localparam logic [6:0] ADDR_PKT_CFG_2   = 7'h3d;
   localparam logic [6:0] ADDR_KEY_FIRST   = 7'h3e;
   localparam logic [6:0] ADDR_KEY_LAST    = 7'h4d;
   localparam logic [6:0] ADDR_TEMP_CTRL   = 7'h4e;
   localparam logic [6:0] ADDR_TEMP_VAL    = 7'h4f;
   localparam logic [6:0] ADDR_SENS_BOOST  = 7'h58;
   localparam logic [6:0] ADDR_OOK_ADJUST  = 7'h6e;

   // Operating mode register fields
   localparam int OPM_SEQ_OFF_BIT = 7;
   localparam int OPM_LISTEN_BIT  = 6;
   localparam int OPM_ABORT_BIT   = 5;
   localparam int OPM_MODE_HI     = 4;
   localparam int OPM_MODE_LO     = 2;

   // Data and modulation register fields
   localparam int DM_PROC_HI  = 6;
   localparam int DM_PROC_LO  = 5;
   localparam int DM_MOD_HI   = 4;
   localparam int DM_MOD_LO   = 3;
   localparam int DM_SHAPE_HI = 1;
   localparam int DM_SHAPE_LO = 0;
   localparam logic [7:0] DM_WRITE_MASK = 8'h7b;

   // Transceiver modes
   localparam logic [2:0] MODE_SLEEP   = 3'h0;
   localparam logic [2:0] MODE_STANDBY = 3'h1;
   localparam logic [2:0] MODE_SYNTH   = 3'h2;
   localparam logic [2:0] MODE_TX      = 3'h3;
   localparam logic [2:0] MODE_RX      = 3'h4;

   // Data processing, modulation and shaping codes
   localparam logic [1:0] PROC_PACKET  = 2'h0;
   localparam logic [1:0] PROC_CONT_BS = 2'h2;
   localparam logic [1:0] PROC_CONT_NB = 2'h3;
   localparam logic [1:0] MOD_FSK      = 2'h0;
   localparam logic [1:0] MOD_OOK      = 2'h1;

   typedef enum logic [2:0] {
      SHAPE_NONE  = 3'h0,
      SHAPE_BT_10 = 3'h1,
      SHAPE_BT_05 = 3'h2,
      SHAPE_BT_03 = 3'h3,
      SHAPE_CUT_1 = 3'h4,
      SHAPE_CUT_2 = 3'h5,
      SHAPE_RSVD  = 3'h7
   } shaping_t;

   // Sequencer settling per step
   localparam int CLK_PERIOD_PS   = 4000;
   localparam int SEQ_STEP_NS     = 100;
   localparam int SEQ_STEP_CYCLES = (SEQ_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Status inputs from the radio core
   typedef struct packed {
      logic [6:0] flagsFirst;   // Lock, timeout, signal strength and friends
      logic [7:1] flagsSecond;  // FIFO handling flags, low supply
   } radio_status_t;

   // Measured values shown in read-only registers
   typedef struct packed {
      logic [7:0] afcHigh;
      logic [7:0] afcLow;
      logic [7:0] feiHigh;
      logic [7:0] feiLow;
      logic [7:0] rssi;
      logic [7:0] temp;
   } radio_measure_t;

   // Control values driven into the radio core
   typedef struct packed {
      logic [2:0]       actualMode;
      logic             modeReady;
      logic             listenEnable;
      logic             listenAbortPulse;
      logic [1:0]       dataProcessing;
      logic [1:0]       modulationType;
      shaping_t         shaping;
      logic [15:8]      bitRateDivisorHigh;
      logic [7:0]       channelBandwidth;
      logic [3:0][1:0]  digitalPinSelectLow;
      logic [1:0]       digitalPinFourSelect;
      logic [1:0]       digitalPinFiveSelect;
      logic [2:0]       clockOutputDivide;
      logic [7:0]       rxDetectTimeout;
      logic [7:0]       rxPayloadTimeout;
      logic [7:0][7:0]  syncWord;
      logic [7:0]       fifoThreshold;
      logic [15:0][7:0] cipherKey;
   } radio_ctrl_t;

   // Built-in value loaded at power-on reset
   function automatic logic [7:0] resetValue(input logic [6:0] a);
      unique case (a)
         ADDR_OP_MODE:     resetValue = 8'h04;
         ADDR_BIT_RATE_DIVISOR_HI:  resetValue = 8'h1a;
         ADDR_RX_BW:       resetValue = 8'h86;
         ADDR_AFC_BW:      resetValue = 8'h8a;
         ADDR_OOK_PEAK:    resetValue = 8'h40;
         ADDR_OOK_AVG:     resetValue = 8'h80;
         ADDR_OOK_FIX:     resetValue = 8'h06;
         ADDR_AFC_CTRL:    resetValue = 8'h10;
         ADDR_RSSI_CFG:    resetValue = 8'h02;
         ADDR_PIN_MAP_HI:  resetValue = 8'h05;
         ADDR_RSSI_THR:    resetValue = 8'hff;
         ADDR_PREAMB_LO:   resetValue = 8'h03;
         ADDR_SYNC_CFG:    resetValue = 8'h98;
         ADDR_PKT_CFG_1:   resetValue = 8'h10;
         ADDR_PAYLOAD_LEN: resetValue = 8'h40;
         ADDR_FIFO_THR:    resetValue = 8'h0f;
         ADDR_PKT_CFG_2:   resetValue = 8'h02;
         ADDR_TEMP_CTRL:   resetValue = 8'h01;
         ADDR_SENS_BOOST:  resetValue = 8'h1b;
         ADDR_OOK_ADJUST:  resetValue = 8'h06;
         default:          resetValue = 8'h00;
      endcase
   endfunction

   // Host-writable storage locations
   function automatic logic isStored(input logic [6:0] a);
      isStored = (a >= ADDR_OP_MODE && a <= ADDR_BIT_RATE_DIVISOR_HI)
              || (a >= ADDR_RX_BW && a <= ADDR_AFC_CTRL)
              || a == ADDR_RSSI_CFG
              || (a >= ADDR_PIN_MAP_LO && a <= ADDR_PIN_MAP_HI)
              || (a >= ADDR_RSSI_THR && a <= ADDR_TEMP_CTRL)
              || a == ADDR_SENS_BOOST || a == ADDR_OOK_ADJUST;
   endfunction

endpackage

// ---- verif/radio_map_properties.sv ----
/* Assertions on the control outputs of the register map.
   Assumes a bind onto radio_config_register_map. */
`timescale 1ns/1ps
`default_nettype none
module radio_map_properties
   import radio_config_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        afcRunning,
   input wire radio_ctrl_t ctrl
);
   // One clock domain; reset blanks every check
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   rate_reset_a:
      assert property ($fell(reset) |-> ctrl.bitRateDivisorHigh == 8'h1a
         && ctrl.fifoThreshold == 8'h0f) else $error("rate or threshold reset wrong");
   mode_reset_a:
      assert property ($fell(reset) |-> ctrl.actualMode == MODE_STANDBY
         && !ctrl.listenEnable) else $error("mode reset wrong");
   key_reset_a:
      assert property ($fell(reset) |-> ctrl.cipherKey == '0 && ctrl.syncWord == '0
         && ctrl.clockOutputDivide == 3'h5) else $error("key or pin reset wrong");
   bw_select_a:
      assert property ($fell(reset) |-> ctrl.channelBandwidth
         == (afcRunning ? 8'h8a : 8'h86)) else $error("bandwidth select wrong");
   abort_pulse_a:
      assert property (ctrl.listenAbortPulse |=> !ctrl.listenAbortPulse)
         else $error("abort pulse too long");
   mode_legal_a:
      assert property (ctrl.actualMode <= MODE_RX) else $error("reserved mode held");
   fsk_shape_a:
      assert property (ctrl.modulationType == MOD_FSK |-> ctrl.shaping inside
         {SHAPE_NONE, SHAPE_BT_10, SHAPE_BT_05, SHAPE_BT_03}) else $error("bad fsk shape");
   ook_shape_a:
      assert property (ctrl.modulationType == MOD_OOK |-> ctrl.shaping inside
         {SHAPE_NONE, SHAPE_CUT_1, SHAPE_CUT_2, SHAPE_RSVD}) else $error("bad ook shape");
endmodule // radio_map_properties
bind radio_config_register_map radio_map_properties chk (.clk(clk), .reset(reset),
   .afcRunning(afcRunning), .ctrl(ctrl));
`default_nettype wire

// ---- verif/spi_host_model.sv ----
/* Host end of the serial link, mode 0, serial clock at clk/5.
   Assumes the device samples on the serial clock rise. */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   input  wire logic clk,
   output logic      sck,
   output logic      mosi,
   output logic      selN,
   input  wire logic miso
);
   // Idle: clock still, frame deselected
   initial begin
      {sck, mosi, selN} = 3'b001;
   end
   // One frame: command byte, then one data byte, MSB first
   task automatic xfer(input logic [15:0] w, output logic [7:0] r);
      @(posedge clk) selN <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         @(posedge clk) {sck, mosi} <= {1'b0, w[i]};
         repeat (2) @(posedge clk);
         r = {r[6:0], miso}; // Taken as the clock rises
         sck <= 1'b1;
         repeat (2) @(posedge clk);
      end
      @(posedge clk) sck <= 1'b0;
      @(posedge clk) {selN, mosi} <= {1'b1, ~mosi}; // Released line keeps moving
   endtask
endmodule // spi_host_model
`default_nettype wire

// ---- verif/tb_radio_config_register_map.sv ----
/* Self-checking bench of the register map through the host model.
   Assumes the package and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
   $display("unexpected %0t: %h not %h", $time, g, e); end end
module tb_radio_config_register_map
   import radio_config_pkg::*;
;
   logic clk = 0, reset = 1, afcRunning = 0, sck, mosi, selN, miso, oe, rdS, wrS, gotValid = 0;
   logic [7:0] wrData, got, expq[$];
   radio_status_t status = '0;
   radio_ctrl_t ctrl;
   int n_mismatch = 0, n_tests = 0, cycles = 0;
   always #2 clk = ~clk;
   radio_config_register_map #(.SEQ_CYCLES(2)) uut (.clk(clk), .reset(reset), .spiSck(sck),
      .spiMosi(mosi), .spiSelectN(selN), .spiMisoOut(miso), .spiMisoOe(oe),
      .afcRunning(afcRunning), .statusIn(status), .measureIn('0), .fifoReadData(8'h00),
      .fifoReadStrobe(rdS), .fifoWriteStrobe(wrS), .fifoWriteData(wrData), .ctrl(ctrl));
   spi_host_model host (.clk(clk), .sck(sck), .mosi(mosi), .selN(selN), .miso(miso));
   // Oldest note against each result; hang guard
   always @(posedge clk) begin
      if (wrS || gotValid) `CHECK(wrS ? wrData : got, expq.pop_front())
      if (++cycles > 20000) begin
         n_mismatch++;
         complete_run();
      end
   end
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      logic [7:0] r;
      expq.push_back(e);
      host.xfer({1'b0, a, 8'h00}, r);
      {got, gotValid} <= {r, 1'b1};
      `CHECK(oe, 1'b1)
      @(posedge clk) gotValid <= 1'b0;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] r;
      host.xfer({1'b1, a, d}, r);
   endtask
   task complete_run;
      if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      logic [7:0] v;
      int e;
      v = 8'($urandom(52));
      status <= 14'($urandom);
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      rd(ADDR_OP_MODE, 8'h04);
      rd(ADDR_FIFO_THR, 8'h0f);
      rd(ADDR_FLAGS_1, {1'b1, status.flagsFirst});
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_DATA_MOD, {4'h0, i[2], 1'b0, i[1:0]});
         e = i < 4 ? i : i == 4 ? 0 : i == 7 ? 7 : i - 1;
         `CHECK(ctrl.shaping, shaping_t'(e))
      end
      wr(ADDR_DATA_MOD, 8'hff);
      rd(ADDR_DATA_MOD, DM_WRITE_MASK);
      for (int m = 0; m < 6; m++) begin
         wr(ADDR_OP_MODE, {3'h4, 3'(m), 2'h0});
         `CHECK(ctrl.actualMode, m < 5 ? 3'(m) : MODE_RX)
      end
      rd(ADDR_OP_MODE, 8'h90);
      wr(ADDR_OP_MODE, 8'h80);
      wr(ADDR_OP_MODE, 8'h10);
      repeat (12) @(posedge clk);
      `CHECK(ctrl.actualMode, MODE_RX)
      wr(ADDR_OP_MODE, 8'h44);
      `CHECK(ctrl.listenEnable, 1'b1)
      wr(ADDR_OP_MODE, 8'h24);
      rd(ADDR_OP_MODE, 8'h04);
      `CHECK(ctrl.listenEnable, 1'b0)
      afcRunning <= 1'b1;
      wr(ADDR_AFC_BW, v);
      `CHECK(ctrl.channelBandwidth, v)
      wr(ADDR_SYNC_LAST, ~v);
      wr(ADDR_KEY_LAST, v);
      `CHECK({ctrl.syncWord[0], ctrl.cipherKey[0]}, {~v, v})
      wr(ADDR_RX_TMO_2, v);
      rd(ADDR_RX_TMO_2, v);
      expq.push_back(~v);
      wr(ADDR_FIFO, ~v);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rd(ADDR_BIT_RATE_DIVISOR_HI, 8'h1a);
      rd(ADDR_KEY_LAST, 8'h00);
      complete_run();
   end
endmodule // tb_radio_config_register_map
`default_nettype wire
